// >>> logic/bsd_regs.svh
`ifndef BSD_REGS_SVH
`define BSD_REGS_SVH
`define BSD_IR_WIDTH 5
`define BSD_OP_EXTEST 5'h00
`define BSD_OP_SAMPLE 5'h01
`define BSD_OP_USER_A 5'h02
`define BSD_OP_USER_B 5'h03
`define BSD_OP_CFG_RD 5'h04
`define BSD_OP_CFG_WR 5'h05
`define BSD_OP_INTEST 5'h07
`define BSD_OP_USERID 5'h08
`define BSD_OP_IDCODE 5'h09
`define BSD_OP_FLOAT 5'h0a
`define BSD_OP_START 5'h0c
`define BSD_OP_BYPASS 5'h1f
`define BSD_ID_WIDTH 32
`define BSD_ID_VER_LSB 28
`define BSD_ID_FAM_LSB 21
`define BSD_ID_ROW_LSB 12
`define BSD_ID_CO_LSB 1
`endif

// >>> logic/bsd_pkg.sv
package bsd_pkg;
    typedef enum logic [3:0] {
        BSD_RESET = 4'h0, BSD_IDLE = 4'h1, BSD_SEL_DR = 4'h3,
        BSD_CAP_DR = 4'h2, BSD_SH_DR = 4'h6, BSD_EX1_DR = 4'h7,
        BSD_PA_DR = 4'h5, BSD_EX2_DR = 4'h4, BSD_UP_DR = 4'hc,
        BSD_SEL_IR = 4'hd, BSD_CAP_IR = 4'hf, BSD_SH_IR = 4'he,
        BSD_EX1_IR = 4'ha, BSD_PA_IR = 4'hb, BSD_EX2_IR = 4'h9,
        BSD_UP_IR = 4'h8
    } bsd_tap_t;
endpackage : bsd_pkg

// >>> logic/bsd_tap_if.sv
interface bsd_tap_if;
    logic tck_rise;
    logic tck_fall;
    logic tms;
    bsd_pkg::bsd_tap_t state;
    modport ctl (input tck_rise, input tms, output state);
    modport user (input tck_rise, input tck_fall, input state);
endinterface : bsd_tap_if

// >>> logic/bsd_tap_fsm.sv
`include "bsd_regs.svh"
module bsd_tap_fsm import bsd_pkg::*; (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    bsd_tap_if.ctl tap
);
    typedef struct packed {
        bsd_tap_t st;
    } bsd_fsm_st_t;
    bsd_fsm_st_t cur_ff;
    bsd_fsm_st_t nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        if (tap.tck_rise) begin
            case (cur_ff.st)
                BSD_RESET: nxt_cur.st = tap.tms ? BSD_RESET : BSD_IDLE;
                BSD_IDLE: nxt_cur.st = tap.tms ? BSD_SEL_DR : BSD_IDLE;
                BSD_SEL_DR: nxt_cur.st = tap.tms ? BSD_SEL_IR : BSD_CAP_DR;
                BSD_CAP_DR: nxt_cur.st = tap.tms ? BSD_EX1_DR : BSD_SH_DR;
                BSD_SH_DR: nxt_cur.st = tap.tms ? BSD_EX1_DR : BSD_SH_DR;
                BSD_EX1_DR: nxt_cur.st = tap.tms ? BSD_UP_DR : BSD_PA_DR;
                BSD_PA_DR: nxt_cur.st = tap.tms ? BSD_EX2_DR : BSD_PA_DR;
                BSD_EX2_DR: nxt_cur.st = tap.tms ? BSD_UP_DR : BSD_SH_DR;
                BSD_UP_DR: nxt_cur.st = tap.tms ? BSD_SEL_DR : BSD_IDLE;
                BSD_SEL_IR: nxt_cur.st = tap.tms ? BSD_RESET : BSD_CAP_IR;
                BSD_CAP_IR: nxt_cur.st = tap.tms ? BSD_EX1_IR : BSD_SH_IR;
                BSD_SH_IR: nxt_cur.st = tap.tms ? BSD_EX1_IR : BSD_SH_IR;
                BSD_EX1_IR: nxt_cur.st = tap.tms ? BSD_UP_IR : BSD_PA_IR;
                BSD_PA_IR: nxt_cur.st = tap.tms ? BSD_EX2_IR : BSD_PA_IR;
                BSD_EX2_IR: nxt_cur.st = tap.tms ? BSD_UP_IR : BSD_SH_IR;
                BSD_UP_IR: nxt_cur.st = tap.tms ? BSD_SEL_DR : BSD_IDLE;
                default: nxt_cur.st = BSD_RESET;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cur_ff <= '{st: BSD_RESET};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign tap.state = cur_ff.st;

    property p_five_tms_reset;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (tap.tck_rise && tap.tms && cur_ff.st == BSD_SEL_IR)
            |=> cur_ff.st == BSD_RESET;
    endproperty
    a_five_tms_reset: assert property (p_five_tms_reset)
        else $error("select-ir with mode high did not reach reset");

    property p_hold_without_edge;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !tap.tck_rise |=> $stable(cur_ff.st);
    endproperty
    a_hold_without_edge: assert property (p_hold_without_edge)
        else $error("tap state moved without a test clock edge");
endmodule : bsd_tap_fsm

// >>> logic/bsd_scan_top.sv
// Functional notes
// - Boundary register holds input, output and enable cells per I/O pin.
// - Within a pin the cells chain input, output, then enable.
// - Receive-only pins add just the input cell.
// - External test capture loads all boundary cells from pin values.
// - Bypass is one flip-flop between data in and data out.
// - Chain selects assert while user codes 00010 and 00011 are loaded.
// - Under a user code the matching return input drives data out.
// - Each user chain gets its own shift clock output.
// - User chains share data in and reset, shift, update state flags.
// - Five-bit instruction decode; unlisted codes are reserved.
// - Codes 00100 and 00101 reach the configuration bus, read and write.
// - Code 01001 shifts out the 32-bit identification word.
// - Code 01010 floats all outputs and selects bypass.
// - Identification word: version, family, rows, company, then a one.
// - Code 01000 shifts out the user identification word.
// - User identification word is meaningful only after configuration.
// - Cell 0 sits nearest data out.
// - User chain codes are unavailable before configuration completes.
`include "bsd_regs.svh"
module bsd_scan_top import bsd_pkg::*; #(
    parameter int IO_PINS = 4,
    parameter int IN_PINS = 2,
    parameter logic [3:0] DIE_VERSION = 4'h0,
    parameter logic [6:0] FAMILY_CODE = 7'h00, // Arbitrary value
    parameter logic [8:0] ROW_COUNT = 9'h000, // Arbitrary value
    parameter logic [10:0] COMPANY_CODE = 11'h000 // Arbitrary value
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    input wire logic [IO_PINS-1:0] pin_in,
    input wire logic [IN_PINS-1:0] in_only_pin_in,
    input wire logic [IO_PINS-1:0] core_out_in,
    input wire logic [IO_PINS-1:0] core_oe_in,
    output logic [IO_PINS-1:0] pin_out,
    output logic [IO_PINS-1:0] pin_oe_out,
    input wire logic config_done_in,
    input wire logic [31:0] user_id_word_in,
    input wire logic cfg_rd_data_in,
    output logic cfg_rd_sel_out,
    output logic cfg_wr_sel_out,
    output logic startup_clock_out,
    input wire logic user_chain_return_a_in,
    input wire logic user_chain_return_b_in,
    output logic user_chain_select_a_out,
    output logic user_chain_select_b_out,
    output logic user_chain_shift_clock_a_out,
    output logic user_chain_shift_clock_b_out,
    output logic user_tdi_out,
    output logic user_reset_out,
    output logic user_shift_out,
    output logic user_update_out
);
    localparam int BSR_LEN = IN_PINS + 3 * IO_PINS;

    // Refuse pin counts that leave a port or the chain without a bit
    if (IO_PINS < 1 || IN_PINS < 1) begin : g_bad_pins
        $error("pin counts out of range");
    end

    typedef struct packed {
        logic [2:0] tck_sync;
        logic [1:0] tms_sync;
        logic [1:0] tdi_sync;
        logic [`BSD_IR_WIDTH-1:0] ir_sh;
        logic [`BSD_IR_WIDTH-1:0] ir;
        logic [BSR_LEN-1:0] bsr_sh;
        logic [BSR_LEN-1:0] bsr_up;
        logic [`BSD_ID_WIDTH-1:0] id_sh;
        logic bypass;
        logic tdo;
        logic tdo_oe;
        logic drck_a;
        logic drck_b;
    } bsd_top_st_t;
    bsd_top_st_t cur_ff;
    bsd_top_st_t nxt_cur;

    bsd_tap_if tap ();
    logic tck_rise;
    logic tck_fall;
    logic [BSR_LEN-1:0] bsr_cap;
    logic [`BSD_ID_WIDTH-1:0] id_word;
    logic [`BSD_IR_WIDTH-1:0] op;
    logic sel_dr_bit;
    logic user_a;
    logic user_b;
    logic bsr_op;
    logic float_op;
    logic ext_op;

    function automatic logic is_user(input logic [`BSD_IR_WIDTH-1:0] c,
                                     input logic [`BSD_IR_WIDTH-1:0] u,
                                     input logic done);
        is_user = (c == u) && done;
    endfunction : is_user

    assign tck_rise = cur_ff.tck_sync[1] && !cur_ff.tck_sync[2];
    assign tck_fall = !cur_ff.tck_sync[1] && cur_ff.tck_sync[2];
    assign tap.tck_rise = tck_rise;
    assign tap.tck_fall = tck_fall;
    assign tap.tms = cur_ff.tms_sync[1];

    bsd_tap_fsm u_fsm (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .tap(tap)
    );

    assign op = cur_ff.ir;
    assign user_a = is_user(op, `BSD_OP_USER_A, config_done_in);
    assign user_b = is_user(op, `BSD_OP_USER_B, config_done_in);
    assign bsr_op = op == `BSD_OP_EXTEST || op == `BSD_OP_SAMPLE ||
                    op == `BSD_OP_INTEST;
    assign ext_op = op == `BSD_OP_EXTEST || op == `BSD_OP_INTEST;
    assign float_op = op == `BSD_OP_FLOAT;

    assign id_word = {DIE_VERSION, FAMILY_CODE, ROW_COUNT, COMPANY_CODE,
                      1'b1};

    // Capture: input-only cells first, then per pin input, output, enable
    generate
        for (genvar g = 0; g < IN_PINS; g++) begin : g_in_only
            assign bsr_cap[g] = in_only_pin_in[g];
        end
        for (genvar g = 0; g < IO_PINS; g++) begin : g_io
            assign bsr_cap[IN_PINS + 3*g] = pin_in[g];
            assign bsr_cap[IN_PINS + 3*g + 1] = pin_out[g];
            assign bsr_cap[IN_PINS + 3*g + 2] = pin_oe_out[g];
            assign pin_out[g] = ext_op ? cur_ff.bsr_up[IN_PINS + 3*g + 1]
                                       : core_out_in[g];
            assign pin_oe_out[g] = float_op ? 1'b0
                : ext_op ? cur_ff.bsr_up[IN_PINS + 3*g + 2]
                : core_oe_in[g];
        end
    endgenerate

    // Data register tail selected by the current instruction
    always_comb begin
        if (bsr_op) begin
            sel_dr_bit = cur_ff.bsr_sh[0];
        end else if (op == `BSD_OP_IDCODE || op == `BSD_OP_USERID) begin
            sel_dr_bit = cur_ff.id_sh[0];
        end else if (user_a) begin
            sel_dr_bit = user_chain_return_a_in;
        end else if (user_b) begin
            sel_dr_bit = user_chain_return_b_in;
        end else if (op == `BSD_OP_CFG_RD) begin
            sel_dr_bit = cfg_rd_data_in;
        end else begin
            sel_dr_bit = cur_ff.bypass;
        end
    end

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.tck_sync = {cur_ff.tck_sync[1:0], tck_in};
        nxt_cur.tms_sync = {cur_ff.tms_sync[0], tms_in};
        nxt_cur.tdi_sync = {cur_ff.tdi_sync[0], tdi_in};
        nxt_cur.drck_a = 1'b1;
        nxt_cur.drck_b = 1'b1;
        if (tck_rise) begin
            case (tap.state)
                BSD_RESET: begin
                    nxt_cur.ir = `BSD_OP_IDCODE;
                end
                BSD_CAP_IR: begin
                    nxt_cur.ir_sh = 5'h01;
                end
                BSD_SH_IR: begin
                    nxt_cur.ir_sh = {cur_ff.tdi_sync[1],
                                     cur_ff.ir_sh[`BSD_IR_WIDTH-1:1]};
                end
                BSD_UP_IR: begin
                    nxt_cur.ir = cur_ff.ir_sh;
                end
                BSD_CAP_DR: begin
                    nxt_cur.bypass = 1'b0;
                    if (bsr_op) begin
                        nxt_cur.bsr_sh = bsr_cap;
                    end
                    if (op == `BSD_OP_USERID) begin
                        nxt_cur.id_sh = user_id_word_in;
                    end else begin
                        nxt_cur.id_sh = id_word;
                    end
                end
                BSD_SH_DR: begin
                    nxt_cur.bypass = cur_ff.tdi_sync[1];
                    nxt_cur.bsr_sh = {cur_ff.tdi_sync[1],
                                      cur_ff.bsr_sh[BSR_LEN-1:1]};
                    nxt_cur.id_sh = {cur_ff.tdi_sync[1],
                                     cur_ff.id_sh[`BSD_ID_WIDTH-1:1]};
                end
                BSD_UP_DR: begin
                    if (bsr_op) begin
                        nxt_cur.bsr_up = cur_ff.bsr_sh;
                    end
                end
                default: begin
                end
            endcase
        end
        // Shift clocks run low between edges in capture and shift only
        if (tap.state == BSD_CAP_DR || tap.state == BSD_SH_DR) begin
            if (cur_ff.tck_sync[1] == 1'b0) begin
                nxt_cur.drck_a = !user_a;
                nxt_cur.drck_b = !user_b;
            end
        end
        if (tck_fall) begin
            nxt_cur.tdo_oe = tap.state == BSD_SH_DR ||
                             tap.state == BSD_SH_IR;
            nxt_cur.tdo = tap.state == BSD_SH_IR ? cur_ff.ir_sh[0]
                                                 : sel_dr_bit;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cur_ff <= '0;
            cur_ff.ir <= `BSD_OP_IDCODE;
            cur_ff.drck_a <= 1'b1;
            cur_ff.drck_b <= 1'b1;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign tdo_out = cur_ff.tdo;
    assign tdo_oe_out = cur_ff.tdo_oe;
    assign cfg_rd_sel_out = op == `BSD_OP_CFG_RD;
    assign cfg_wr_sel_out = op == `BSD_OP_CFG_WR;
    assign startup_clock_out = op == `BSD_OP_START && cur_ff.tck_sync[2];
    assign user_chain_select_a_out = user_a;
    assign user_chain_select_b_out = user_b;
    assign user_chain_shift_clock_a_out = cur_ff.drck_a;
    assign user_chain_shift_clock_b_out = cur_ff.drck_b;
    assign user_tdi_out = cur_ff.tdi_sync[1];
    assign user_reset_out = tap.state == BSD_RESET;
    assign user_shift_out = tap.state == BSD_SH_DR;
    assign user_update_out = tap.state == BSD_UP_DR;

    property p_bypass_path;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (tck_rise && tap.state == BSD_SH_DR) |=>
            cur_ff.bypass == $past(cur_ff.tdi_sync[1]);
    endproperty
    a_bypass_path: assert property (p_bypass_path)
        else $error("bypass bit did not take data in");

    property p_user_sel;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        user_chain_select_a_out |-> op == 5'h02 && config_done_in;
    endproperty
    a_user_sel: assert property (p_user_sel)
        else $error("chain a select without its code");

    property p_user_b_sel;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (op == 5'h03 && config_done_in) |-> user_chain_select_b_out
            && !user_chain_select_a_out;
    endproperty
    a_user_b_sel: assert property (p_user_b_sel)
        else $error("chain b select missing");

    property p_float;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        op == 5'h0a |-> pin_oe_out == '0;
    endproperty
    a_float: assert property (p_float)
        else $error("outputs driven under float code");

    property p_capture;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (tck_rise && tap.state == BSD_CAP_DR && op == 5'h00) |=>
            cur_ff.bsr_sh == $past(bsr_cap);
    endproperty
    a_capture: assert property (p_capture)
        else $error("boundary capture missed pin values");

    property p_id_lsb;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (tck_rise && tap.state == BSD_CAP_DR && op == 5'h09) |=>
            cur_ff.id_sh[0] == 1'b1;
    endproperty
    a_id_lsb: assert property (p_id_lsb)
        else $error("id word lsb not one");

    property p_user_ret;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (tck_fall && tap.state == BSD_SH_DR && user_a) |=>
            tdo_out == $past(user_chain_return_a_in);
    endproperty
    a_user_ret: assert property (p_user_ret)
        else $error("chain a return not on data out");

    property p_shift_flag;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (tck_rise && tap.state == BSD_CAP_DR && !tap.tms) |=>
            user_shift_out && !user_update_out;
    endproperty
    a_shift_flag: assert property (p_shift_flag)
        else $error("shift flag wrong");

    c_user_a: cover property (@(posedge clk_sys_in) user_a && tck_rise);
    c_extest: cover property (@(posedge clk_sys_in)
        tap.state == BSD_CAP_DR && op == 5'h00);
    c_float: cover property (@(posedge clk_sys_in) float_op);
endmodule : bsd_scan_top

// >>> testbench/bsd_jtag_ctl.sv
module bsd_jtag_ctl (
    input wire logic clk_sys_in,
    input wire logic tdo_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
    end

    // One test clock period of 8 system clocks; data out is taken at the rise
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge clk_sys_in);
        #1;
        tck_out = 1'b0;
        tms_out = m;
        tdi_out = d;
        repeat (4) @(posedge clk_sys_in);
        #1;
        q = tdo_in;
        tck_out = 1'b1;
        repeat (3) @(posedge clk_sys_in);
    endtask : step

    // Test clock stands low between frames; released data line toggles
    task automatic park();
        @(posedge clk_sys_in);
        #1;
        tck_out = 1'b0;
        tdi_out = ~tdi_out;
    endtask : park

    task automatic tap_reset();
        logic q;
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        park();
    endtask : tap_reset

    // From idle: one instruction or data scan, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) begin
            step(1'b1, 1'b0, q);
        end
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        park();
    endtask : scan
endmodule : bsd_jtag_ctl

// >>> testbench/bsd_scan_top_tb.sv
`include "bsd_regs.svh"
module bsd_scan_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] VER = 4'h5; // Arbitrary value
    localparam logic [6:0] FAM = 7'h2a; // Arbitrary value
    localparam logic [8:0] ROWS = 9'h13c; // Arbitrary value
    localparam logic [10:0] CO = 11'h2d5; // Arbitrary value
    logic clk_sys_in, sys_rst_in, tck, tms, tdi, tdo, tdo_oe;
    logic [3:0] pin_in, core_out, core_oe, pin_out, pin_oe;
    logic [1:0] in_only;
    logic [31:0] uid, d;
    logic done, cfg_rd, rd_sel, wr_sel, st_clk, ret_a, ret_b, sel_a, sel_b;
    logic sck_a, sck_b, u_tdi, u_rst, u_sh, u_up;
    int fails = 0;
    int tests_run = 0;
    int lo_a, lo_b, st_hi, sh_hi, up_hi, rs_hi, oe_hi;

    bsd_scan_top #(
        .IO_PINS(4), .IN_PINS(2), .DIE_VERSION(VER), .FAMILY_CODE(FAM),
        .ROW_COUNT(ROWS), .COMPANY_CODE(CO)
    ) DUT (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .tck_in(tck),
        .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .pin_in(pin_in), .in_only_pin_in(in_only), .core_out_in(core_out),
        .core_oe_in(core_oe), .pin_out(pin_out), .pin_oe_out(pin_oe),
        .config_done_in(done), .user_id_word_in(uid),
        .cfg_rd_data_in(cfg_rd), .cfg_rd_sel_out(rd_sel),
        .cfg_wr_sel_out(wr_sel), .startup_clock_out(st_clk),
        .user_chain_return_a_in(ret_a), .user_chain_return_b_in(ret_b),
        .user_chain_select_a_out(sel_a), .user_chain_select_b_out(sel_b),
        .user_chain_shift_clock_a_out(sck_a),
        .user_chain_shift_clock_b_out(sck_b), .user_tdi_out(u_tdi),
        .user_reset_out(u_rst), .user_shift_out(u_sh),
        .user_update_out(u_up)
    );

    bsd_jtag_ctl JT (
        .clk_sys_in(clk_sys_in), .tdo_in(tdo), .tck_out(tck),
        .tms_out(tms), .tdi_out(tdi)
    );

    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    // Activity counters for user chain clock and state outputs, startup clock and data out enable
    always @(posedge clk_sys_in) begin
        if (sck_a === 1'b0) lo_a++;
        if (sck_b === 1'b0) lo_b++;
        if (st_clk === 1'b1) st_hi++;
        if (u_sh === 1'b1) sh_hi++;
        if (u_up === 1'b1) up_hi++;
        if (u_rst === 1'b1) rs_hi++;
        if (tdo_oe === 1'b1) oe_hi++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic ir(input logic [4:0] c);
        JT.scan(1'b1, 5, {27'h0, c}, d);
    endtask : ir

    // Expected chain: input-only cells first, then input, output, enable
    function automatic logic [31:0] cells(input logic [3:0] pv, ov, ev);
        logic [31:0] c;
        c = {30'h0, in_only};
        for (int p = 0; p < 4; p++) begin
            c[2 + 3 * p] = pv[p];
            c[3 + 3 * p] = ov[p];
            c[4 + 3 * p] = ev[p];
        end
        return c;
    endfunction : cells

    task automatic t_idcode();
        logic [31:0] id;
        id = {VER, FAM, ROWS, CO, 1'b1};
        JT.tap_reset();
        chk({31'h0, rs_hi > 0}, 32'h1, "reset flag");
        JT.scan(1'b0, 32, 32'h0, d);
        chk(d, id, "id after reset");
        ir(`BSD_OP_IDCODE);
        chk(d, 32'h1, "ir capture");
        oe_hi = 0;
        JT.scan(1'b0, 32, 32'h0, d);
        chk(d, id, "id code");
        chk(oe_hi, 32'h100, "data out enable");
        chk({31'h0, tdo_oe}, 32'h0, "data out idle");
        $display("test idcode done");
    endtask : t_idcode

    task automatic t_bypass();
        logic [4:0] codes [3] = '{`BSD_OP_BYPASS, 5'h1e, `BSD_OP_FLOAT};
        core_oe = 4'hb;
        foreach (codes[i]) begin
            ir(codes[i]);
            chk({28'h0, pin_oe}, (codes[i] == `BSD_OP_FLOAT) ? 32'h0 : 32'hb,
                "output enables");
            JT.scan(1'b0, 8, 32'hb5, d);
            chk(d, 32'h6a, "single stage delay");
        end
        $display("test bypass done");
    endtask : t_bypass

    task automatic t_boundary();
        logic [31:0] pre;
        done = 1'b1;
        in_only = 2'b10;
        pin_in = 4'h6;
        core_out = 4'ha;
        core_oe = 4'hc;
        pre = cells(4'h0, 4'h5, 4'h3);
        ir(`BSD_OP_SAMPLE);
        chk(d, 32'h1, "ir capture");
        JT.scan(1'b0, 14, pre, d);
        chk(d, cells(4'h6, 4'ha, 4'hc),
            "sample");
        ir(`BSD_OP_EXTEST);
        chk({24'h0, pin_oe, pin_out}, 32'h35, "preloaded drive");
        pin_in = 4'h9;
        JT.scan(1'b0, 14, 32'h0, d);
        chk(d, cells(4'h9, 4'h5, 4'h3), "external capture");
        ir(`BSD_OP_INTEST);
        chk({24'h0, pin_oe, pin_out}, 32'h0, "internal drive");
        $display("test boundary done");
    endtask : t_boundary

    task automatic t_user();
        done = 1'b0;
        ret_a = 1'b1;
        ir(`BSD_OP_USER_A);
        chk({31'h0, sel_a}, 32'h0, "select unconfigured");
        JT.scan(1'b0, 4, 32'h5, d);
        chk(d, 32'ha, "user code as bypass");
        done = 1'b1;
        for (int k = 0; k < 2; k++) begin
            ir(k == 0 ? `BSD_OP_USER_A : `BSD_OP_USER_B);
            chk({30'h0, sel_b, sel_a}, 32'h1 << k, "select");
            ret_a = (k == 0);
            ret_b = (k == 1);
            lo_a = 0;
            lo_b = 0;
            sh_hi = 0;
            up_hi = 0;
            JT.scan(1'b0, 4, 32'h0, d);
            chk(d, 32'hf, "return data");
            chk({31'h0, (k == 0 ? lo_a : lo_b) > 0}, 32'h1,
                "own clk");
            chk(k == 0 ? lo_b : lo_a, 32'h0, "other clk");
            chk({30'h0, sh_hi > 0, up_hi > 0}, 32'h3, "flags");
        end
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk({31'h0, u_tdi}, {31'h0, tdi}, "user data in");
        $display("test user chains done");
    endtask : t_user

    task automatic t_misc();
        uid = 32'h3c5a0f96;
        ir(`BSD_OP_USERID);
        JT.scan(1'b0, 32, 32'h0, d);
        chk(d, uid, "user id word");
        ir(`BSD_OP_CFG_RD);
        chk({30'h0, wr_sel, rd_sel}, 32'h1, "config read");
        cfg_rd = 1'b1;
        JT.scan(1'b0, 4, 32'h0, d);
        chk(d, 32'hf, "config read data");
        ir(`BSD_OP_CFG_WR);
        chk({30'h0, wr_sel, rd_sel}, 32'h2, "config write");
        ir(`BSD_OP_START);
        st_hi = 0;
        JT.scan(1'b0, 2, 32'h0, d);
        chk({31'h0, st_hi > 0}, 32'h1, "startup clock");
        $display("test misc codes done");
    endtask : t_misc

    initial begin
        sys_rst_in = 1'b1;
        pin_in = 4'h0;
        in_only = 2'b00;
        core_out = 4'h0;
        core_oe = 4'h0;
        done = 1'b0;
        uid = 32'h0;
        cfg_rd = 1'b0;
        ret_a = 1'b0;
        ret_b = 1'b0;
        repeat (2) @(posedge clk_sys_in);
        #1;
        sys_rst_in = 1'b0;
        t_idcode();
        t_bypass();
        t_boundary();
        t_user();
        t_misc();
        stop_test();
    end

    initial begin
        #400000;
        fails++;
        $display("BAD %0t watchdog expired", $time);
        stop_test();
    end
endmodule : bsd_scan_top_tb
